// ---- alu_pkg.sv ----
package alu_pkg;

   // ****************************************************************
   // data widths
   // ****************************************************************
   localparam int DATA_W = 8;        // datapath byte width
   localparam int FILE_ADDR_W = 5;   // file register address width
   localparam int FILE_DEPTH = 32;   // file registers, address 0 to 31
   localparam int BUS_ADDR_W = 8;    // byte address bits decoded on the bus

   // ****************************************************************
   // register byte offsets
   // ****************************************************************
   localparam logic [BUS_ADDR_W-1:0] OFS_INSTR = 8'h00;  // write executes
   localparam logic [BUS_ADDR_W-1:0] OFS_ACC = 8'h04;    // accumulator
   localparam logic [BUS_ADDR_W-1:0] OFS_STATUS = 8'h08; // carry and zero
   localparam logic [BUS_ADDR_W-1:0] OFS_DIR = 8'h0c;    // port direction, read only
   localparam logic [BUS_ADDR_W-1:0] OFS_FPTR = 8'h10;   // file access pointer
   localparam logic [BUS_ADDR_W-1:0] OFS_FDATA = 8'h14;  // file[pointer]

   // ****************************************************************
   // field positions and values
   // ****************************************************************
   localparam int ST_CARRY_BIT = 0;  // status bit of carry
   localparam int ST_ZERO_BIT = 1;   // status bit of zero
   localparam logic [FILE_ADDR_W-1:0] DIR_OPERAND = 5'h06; // only direction operand that is acted on
   localparam logic [DATA_W-1:0] ACC_RST = 8'h00;
   localparam logic [DATA_W-1:0] DIR_RST = 8'hff;  // all pins input after reset
   localparam logic [DATA_W-1:0] ZERO_BYTE = 8'h00;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // ****************************************************************
   // instruction word written to the execute register
   // ****************************************************************
   typedef enum logic [2:0] {
      OP_NONE = 3'b000,
      OP_ROTATE_RIGHT_CARRY = 3'b001,
      OP_NIBBLE_EXCHANGE = 3'b010,
      OP_PIN_DIRECTION_LOAD = 3'b011,
      OP_XOR_REG_ACC = 3'b100,
      OP_XOR_LITERAL_ACC = 3'b101
   } op_t;

   typedef struct packed {
      logic [7:0] pad_hi;               // reads zero
      logic [DATA_W-1:0] literal;       // immediate 0..255
      logic [6:0] pad_lo;               // reads zero
      logic [FILE_ADDR_W-1:0] faddr;    // file register operand
      logic dest;                       // 0 accumulator, 1 file register
      logic [2:0] op;                   // op_t code
   } instr_t;

   localparam instr_t INSTR_RST = '0;

endpackage : alu_pkg

// ---- byte_rotate_swap_xor_alu.sv ----
// The implementer's own choices: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/1ns

// Summary of operation
// - rotate file right through carry, carry only
// - rotate result to accumulator or file by dest
// - swap nibbles, dest selectable, no flags
// - accumulator loads direction register, operand six
// - xor accumulator with file, zero only
// - file xor result to accumulator or file
// - xor accumulator with literal, into accumulator
module byte_rotate_swap_xor_alu #(
   parameter int FILE_DEPTH = alu_pkg::FILE_DEPTH
) (
   input wire logic ref_clk_i,
   input wire logic rst_i,
   // axi4-lite write address
   input wire logic [31:0] s_axi_awaddr_i,
   input wire logic s_axi_awvalid_i,
   output logic s_axi_awready_o,
   // axi4-lite write data
   input wire logic [31:0] s_axi_wdata_i,
   input wire logic [3:0] s_axi_wstrb_i,
   input wire logic s_axi_wvalid_i,
   output logic s_axi_wready_o,
   // axi4-lite write response
   output logic [1:0] s_axi_bresp_o,
   output logic s_axi_bvalid_o,
   input wire logic s_axi_bready_i,
   // axi4-lite read address
   input wire logic [31:0] s_axi_araddr_i,
   input wire logic s_axi_arvalid_i,
   output logic s_axi_arready_o,
   // axi4-lite read data
   output logic [31:0] s_axi_rdata_o,
   output logic [1:0] s_axi_rresp_o,
   output logic s_axi_rvalid_o,
   input wire logic s_axi_rready_i,
   // core state seen by the rest of the chip
   output logic [7:0] acc_o,
   output logic carry_o,
   output logic zero_o,
   output logic [7:0] pin_dir_o
);
   // ****************************************************************
   // elaboration checks
   // ****************************************************************
   // the five-bit operand field can address no more than 32 entries
   if (FILE_DEPTH < 1 || FILE_DEPTH > (1 << alu_pkg::FILE_ADDR_W)) begin : g_depth_check
      $error("FILE_DEPTH must lie between 1 and 32");
   end
   // ****************************************************************
   // bus state
   // ****************************************************************
   logic aw_have_reg, aw_have_next;              // write address held
   logic [7:0] aw_addr_reg, aw_addr_next;
   logic w_have_reg, w_have_next;                // write data held
   logic [31:0] w_data_reg, w_data_next;
   logic [3:0] w_strb_reg, w_strb_next;
   logic bvalid_reg, bvalid_next;
   logic [1:0] bresp_reg, bresp_next;
   logic rvalid_reg, rvalid_next;
   logic [1:0] rresp_reg, rresp_next;
   logic [31:0] rdata_reg, rdata_next;
   logic wr_fire;                                // both halves present, commit now
   logic wr_hit;                                 // commit address is mapped
   logic [31:0] wr_mask;                         // strobes widened to bits
   logic [31:0] rd_word;                         // read mux
   logic rd_hit;
   // ****************************************************************
   // core state
   // ****************************************************************
   logic [7:0] acc_reg, acc_next;
   logic carry_reg, carry_next;
   logic zero_reg, zero_next;
   logic [7:0] dir_reg, dir_next;
   logic [4:0] fptr_reg, fptr_next;              // software file pointer
   alu_pkg::instr_t instr_reg, instr_next;       // last instruction written
   logic [7:0] file_mem [FILE_DEPTH];            // file registers
   logic file_we;
   logic [4:0] file_wa;
   logic [7:0] file_wd;
   // ****************************************************************
   // read mux
   // ****************************************************************
   // reads see the state from before any write committing on the same edge
   always_comb begin
      rd_word = '0;
      rd_hit = 1'b1;
      unique case (s_axi_araddr_i[7:0])
         alu_pkg::OFS_INSTR: rd_word = instr_reg;
         alu_pkg::OFS_ACC: rd_word[7:0] = acc_reg;
         alu_pkg::OFS_STATUS: begin
            rd_word[alu_pkg::ST_CARRY_BIT] = carry_reg;
            rd_word[alu_pkg::ST_ZERO_BIT] = zero_reg;
         end
         alu_pkg::OFS_DIR: rd_word[7:0] = dir_reg;
         alu_pkg::OFS_FPTR: rd_word[4:0] = fptr_reg;
         alu_pkg::OFS_FDATA: rd_word[7:0] = file_mem[fptr_reg];
         default: rd_hit = 1'b0;   // unmapped reads zero with error
      endcase
      // upper address bits beyond the decoded byte are not mapped
      if (s_axi_araddr_i[31:8] != '0) begin
         rd_hit = 1'b0;
         rd_word = '0;
      end
   end
   // ****************************************************************
   // bus next state
   // ****************************************************************
   // one write and one read at a time; ready only while nothing is owed
   always_comb begin
      aw_have_next = aw_have_reg;
      aw_addr_next = aw_addr_reg;
      w_have_next = w_have_reg;
      w_data_next = w_data_reg;
      w_strb_next = w_strb_reg;
      bvalid_next = bvalid_reg;
      bresp_next = bresp_reg;
      rvalid_next = rvalid_reg;
      rresp_next = rresp_reg;
      rdata_next = rdata_reg;
      wr_fire = aw_have_reg && w_have_reg;
      wr_hit = 1'b0;
      // address and data are taken in either order
      if (s_axi_awvalid_i && s_axi_awready_o) begin
         aw_have_next = 1'b1;
         aw_addr_next = s_axi_awaddr_i[7:0];
         if (s_axi_awaddr_i[31:8] != '0) begin
            aw_addr_next = 8'hff;   // forces the unmapped answer
         end
      end
      if (s_axi_wvalid_i && s_axi_wready_o) begin
         w_have_next = 1'b1;
         w_data_next = s_axi_wdata_i;
         w_strb_next = s_axi_wstrb_i;
      end
      // commit one cycle after both halves are in
      if (wr_fire) begin
         aw_have_next = 1'b0;
         w_have_next = 1'b0;
         bvalid_next = 1'b1;
         unique case (aw_addr_reg)
            alu_pkg::OFS_INSTR, alu_pkg::OFS_ACC, alu_pkg::OFS_STATUS,
            alu_pkg::OFS_DIR, alu_pkg::OFS_FPTR, alu_pkg::OFS_FDATA: wr_hit = 1'b1;
            default: wr_hit = 1'b0;
         endcase
         bresp_next = wr_hit ? alu_pkg::RESP_OKAY : alu_pkg::RESP_SLVERR;
      end else if (bvalid_reg && s_axi_bready_i) begin
         bvalid_next = 1'b0;
      end
      // read answered right after the address is taken
      if (s_axi_arvalid_i && s_axi_arready_o) begin
         rvalid_next = 1'b1;
         rdata_next = rd_word;
         rresp_next = rd_hit ? alu_pkg::RESP_OKAY : alu_pkg::RESP_SLVERR;
      end else if (rvalid_reg && s_axi_rready_i) begin
         rvalid_next = 1'b0;
      end
   end
   // ****************************************************************
   // bus registers
   // ****************************************************************
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         aw_have_reg <= 1'b0;
         aw_addr_reg <= '0;
         w_have_reg <= 1'b0;
         w_data_reg <= '0;
         w_strb_reg <= '0;
         bvalid_reg <= 1'b0;
         bresp_reg <= alu_pkg::RESP_OKAY;
         rvalid_reg <= 1'b0;
         rresp_reg <= alu_pkg::RESP_OKAY;
         rdata_reg <= '0;
         s_axi_awready_o <= 1'b0;
         s_axi_wready_o <= 1'b0;
         s_axi_arready_o <= 1'b0;
      end else begin
         aw_have_reg <= aw_have_next;
         aw_addr_reg <= aw_addr_next;
         w_have_reg <= w_have_next;
         w_data_reg <= w_data_next;
         w_strb_reg <= w_strb_next;
         bvalid_reg <= bvalid_next;
         bresp_reg <= bresp_next;
         rvalid_reg <= rvalid_next;
         rresp_reg <= rresp_next;
         rdata_reg <= rdata_next;
         // ready from flops: open only while that half is empty and no answer owed
         s_axi_awready_o <= !aw_have_next && !bvalid_next;
         s_axi_wready_o <= !w_have_next && !bvalid_next;
         s_axi_arready_o <= !rvalid_next;
      end
   end

   assign s_axi_bvalid_o = bvalid_reg;
   assign s_axi_bresp_o = bresp_reg;
   assign s_axi_rvalid_o = rvalid_reg;
   assign s_axi_rresp_o = rresp_reg;
   assign s_axi_rdata_o = rdata_reg;

   // ****************************************************************
   // byte strobe mask, one lane per generate step
   // ****************************************************************
   for (genvar g = 0; g < 4; g++) begin : g_lane
      assign wr_mask[g*8 +: 8] = {8{w_strb_reg[g]}};
   end

   // ****************************************************************
   // datapath next state
   // ****************************************************************
   always_comb begin
      logic [31:0] merged;
      logic [7:0] src;
      logic [7:0] result;
      alu_pkg::instr_t ins;
      merged = '0;
      src = '0;
      result = '0;
      ins = instr_reg;
      acc_next = acc_reg;
      carry_next = carry_reg;
      zero_next = zero_reg;
      dir_next = dir_reg;
      fptr_next = fptr_reg;
      instr_next = instr_reg;
      file_we = 1'b0;
      file_wa = fptr_reg;
      file_wd = '0;
      if (wr_fire && wr_hit) begin
         unique case (aw_addr_reg)
            alu_pkg::OFS_INSTR: begin
               // strobes merge into the old word, then pads forced to zero
               merged = (w_data_reg & wr_mask) | (instr_reg & ~wr_mask);
               ins = merged;
               ins.pad_hi = '0;
               ins.pad_lo = '0;
               instr_next = ins;
               src = file_mem[ins.faddr];
               unique case (ins.op)
                  alu_pkg::OP_ROTATE_RIGHT_CARRY: begin
                     result = {carry_reg, src[7:1]};
                     carry_next = src[0];
                  end
                  alu_pkg::OP_NIBBLE_EXCHANGE: begin
                     result = {src[3:0], src[7:4]};
                  end
                  alu_pkg::OP_PIN_DIRECTION_LOAD: begin
                     // other operands would be a different port: ignored
                     if (ins.faddr == alu_pkg::DIR_OPERAND) begin
                        dir_next = acc_reg;
                     end
                  end
                  alu_pkg::OP_XOR_REG_ACC: begin
                     result = acc_reg ^ src;
                     zero_next = (result == alu_pkg::ZERO_BYTE);
                  end
                  alu_pkg::OP_XOR_LITERAL_ACC: begin
                     result = acc_reg ^ ins.literal;
                     zero_next = (result == alu_pkg::ZERO_BYTE);
                     acc_next = result;
                  end
                  default: ;   // no-op and the two spare codes change nothing
               endcase
               // destination routing for the file-operand group
               if (ins.op == alu_pkg::OP_ROTATE_RIGHT_CARRY ||
                   ins.op == alu_pkg::OP_NIBBLE_EXCHANGE ||
                   ins.op == alu_pkg::OP_XOR_REG_ACC) begin
                  if (ins.dest) begin
                     file_we = 1'b1;
                     file_wa = ins.faddr;
                     file_wd = result;
                  end else begin
                     acc_next = result;
                  end
               end
            end
            alu_pkg::OFS_ACC: begin
               if (w_strb_reg[0]) begin
                  acc_next = w_data_reg[7:0];
               end
            end
            alu_pkg::OFS_STATUS: begin
               if (w_strb_reg[0]) begin
                  carry_next = w_data_reg[alu_pkg::ST_CARRY_BIT];
                  zero_next = w_data_reg[alu_pkg::ST_ZERO_BIT];
               end
            end
            alu_pkg::OFS_FPTR: begin
               if (w_strb_reg[0]) begin
                  fptr_next = w_data_reg[4:0];
               end
            end
            alu_pkg::OFS_FDATA: begin
               file_we = w_strb_reg[0];
               file_wa = fptr_reg;
               file_wd = w_data_reg[7:0];
            end
            default: ;   // direction register is loaded only by instruction
         endcase
      end
   end
   // ****************************************************************
   // datapath registers
   // ****************************************************************
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         acc_reg <= alu_pkg::ACC_RST;
         carry_reg <= 1'b0;
         zero_reg <= 1'b0;
         dir_reg <= alu_pkg::DIR_RST;
         fptr_reg <= '0;
         instr_reg <= alu_pkg::INSTR_RST;
      end else begin
         acc_reg <= acc_next;
         carry_reg <= carry_next;
         zero_reg <= zero_next;
         dir_reg <= dir_next;
         fptr_reg <= fptr_next;
         instr_reg <= instr_next;
      end
   end

   // file contents survive reset, like ordinary data ram
   always_ff @(posedge ref_clk_i) begin
      if (file_we && (32'(file_wa) < FILE_DEPTH)) begin
         file_mem[file_wa] <= file_wd;
      end
   end

   assign acc_o = acc_reg;
   assign carry_o = carry_reg;
   assign zero_o = zero_reg;
   assign pin_dir_o = dir_reg;

endmodule : byte_rotate_swap_xor_alu

// ---- byte_rotate_swap_xor_alu_checker.sv ----
`timescale 1ns/1ns
module byte_rotate_swap_xor_alu_checker #(
   parameter int FILE_DEPTH = alu_pkg::FILE_DEPTH
) (
   input wire logic ref_clk_i,
   input wire logic rst_i,
   input wire logic [31:0] s_axi_awaddr_i,
   input wire logic s_axi_awvalid_i,
   input wire logic s_axi_awready_o,
   input wire logic [31:0] s_axi_wdata_i,
   input wire logic [3:0] s_axi_wstrb_i,
   input wire logic s_axi_wvalid_i,
   input wire logic s_axi_wready_o,
   input wire logic s_axi_bvalid_o,
   input wire logic [7:0] acc_o,
   input wire logic carry_o,
   input wire logic zero_o,
   input wire logic [7:0] pin_dir_o
);
   // ****************************************************************
   // write halves captured at their handshakes
   // ****************************************************************
   logic [31:0] aw_reg, aw_next; // taken address
   logic [35:0] w_reg, w_next; // taken strobes and data
   // next values follow each handshake
   always_comb begin
      aw_next = aw_reg;
      w_next = w_reg;
      if (s_axi_awvalid_i && s_axi_awready_o) aw_next = s_axi_awaddr_i;
      if (s_axi_wvalid_i && s_axi_wready_o) w_next = {s_axi_wstrb_i, s_axi_wdata_i};
   end
   // no reset: only read after a handshake has filled them
   always_ff @(posedge ref_clk_i) begin
      aw_reg <= aw_next;
      w_reg <= w_next;
   end
   // op of the committed word, none unless a full execute write
   wire logic [2:0] op = (aw_reg == 32'h0 && w_reg[35:32] == 4'hf) ? w_reg[2:0] : 3'h0;
   wire logic dst = w_reg[3];
   wire logic [4:0] fa = w_reg[8:4];
   wire logic [7:0] lit = w_reg[23:16];
   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (rst_i);
   // ****************************************************************
   // execution checks at the commit edge
   // ****************************************************************
   a_rot_carry_in: assert property ($rose(s_axi_bvalid_o) && op == 3'h1 && !dst |->
      acc_o[7] == $past(carry_o) && $stable(zero_o)) else $error("rotate carry in wrong");
   a_rot_to_file: assert property ($rose(s_axi_bvalid_o) && op == 3'h1 && dst |->
      $stable(acc_o)) else $error("rotate to file changed acc");
   a_swap_no_flags: assert property ($rose(s_axi_bvalid_o) && op == 3'h2 |->
      $stable(carry_o) && $stable(zero_o)) else $error("swap changed flags");
   a_dir_load: assert property ($rose(s_axi_bvalid_o) && op == 3'h3 && fa == 5'h06 |->
      pin_dir_o == $past(acc_o) && $stable({acc_o, carry_o, zero_o}))
      else $error("direction load wrong");
   a_dir_reject: assert property ($rose(s_axi_bvalid_o) && op == 3'h3 && fa != 5'h06 |->
      $stable(pin_dir_o) [*2]) else $error("direction changed for bad operand");
   a_xreg_carry: assert property ($rose(s_axi_bvalid_o) && op == 3'h4 |->
      $stable(carry_o) && (dst || zero_o == (acc_o == 8'h00))) else $error("xor reg flags wrong");
   a_xreg_file: assert property ($rose(s_axi_bvalid_o) && op == 3'h4 && dst |->
      $stable(acc_o)) else $error("xor to file changed acc");
   a_xlit_acc: assert property ($rose(s_axi_bvalid_o) && op == 3'h5 |->
      acc_o == ($past(acc_o) ^ lit) && $stable(carry_o)) else $error("xor literal wrong");
   a_xlit_zero: assert property ($rose(s_axi_bvalid_o) && op == 3'h5 |->
      zero_o == (acc_o == 8'h00)) else $error("zero flag wrong");
   c_rotate: cover property ($rose(s_axi_bvalid_o) && op == 3'h1);
   c_dir_load: cover property ($rose(s_axi_bvalid_o) && op == 3'h3 && fa == 5'h06);
   c_lit_zero: cover property ($rose(s_axi_bvalid_o) && op == 3'h5 && acc_o == 8'h00);
endmodule : byte_rotate_swap_xor_alu_checker

bind byte_rotate_swap_xor_alu byte_rotate_swap_xor_alu_checker #(.FILE_DEPTH(FILE_DEPTH)) u_chk (
   .ref_clk_i(ref_clk_i), .rst_i(rst_i), .s_axi_awaddr_i(s_axi_awaddr_i),
   .s_axi_awvalid_i(s_axi_awvalid_i), .s_axi_awready_o(s_axi_awready_o),
   .s_axi_wdata_i(s_axi_wdata_i), .s_axi_wstrb_i(s_axi_wstrb_i),
   .s_axi_wvalid_i(s_axi_wvalid_i), .s_axi_wready_o(s_axi_wready_o),
   .s_axi_bvalid_o(s_axi_bvalid_o), .acc_o(acc_o), .carry_o(carry_o), .zero_o(zero_o),
   .pin_dir_o(pin_dir_o)
);

// ---- byte_rotate_swap_xor_alu_tb.sv ----
`timescale 1ns/1ns
module byte_rotate_swap_xor_alu_tb;
   // ****************************************************************
   // clock, reset and bus signals
   // ****************************************************************
   logic ref_clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic [31:0] awaddr = '0, wdata = '0, araddr = '0, rdata;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic awready, wready, bvalid, arready, rvalid, carry, zero;
   logic [1:0] bresp, rresp;
   logic [7:0] acc, pin_dir;
   int err_count = 0;
   int cmp_count = 0;
   // free running core clock
   initial begin
      forever #25 ref_clk_i = ~ref_clk_i;
   end
   // full strobes: every access is a whole word
   byte_rotate_swap_xor_alu DUT (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
      .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
      .s_axi_wdata_i(wdata), .s_axi_wstrb_i(4'hf), .s_axi_wvalid_i(wvalid),
      .s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid),
      .s_axi_bready_i(bready), .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
      .s_axi_arready_o(arready), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
      .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready), .acc_o(acc), .carry_o(carry),
      .zero_o(zero), .pin_dir_o(pin_dir));
   // ****************************************************************
   // shared tasks and the expectation model
   // ****************************************************************
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      cmp_count++;
      if (g !== e) begin
         err_count++;
         $display("mismatch %s expected %h seen %h", n, e, g);
      end
   endtask : chk
   // one write; a leading edge keeps bready from being set twice in a step
   task automatic wr(input logic [31:0] a, input logic [31:0] d, output logic [1:0] r);
      @(posedge ref_clk_i);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge ref_clk_i);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end while (bvalid !== 1'b1);
      r = bresp;
      bready <= 1'b0;
   endtask : wr
   task automatic rd(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
      @(posedge ref_clk_i);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge ref_clk_i);
         if (arready) arvalid <= 1'b0;
      end while (rvalid !== 1'b1);
      d = rdata;
      r = rresp;
      rready <= 1'b0;
   endtask : rd
   // returns {acc, carry, zero, dir, file byte} after one operation
   function automatic logic [25:0] model_step(input logic [2:0] op, input logic d,
         input logic [4:0] fa, input logic [7:0] k, input logic [7:0] a, input logic c,
         input logic z, input logic [7:0] dir, input logic [7:0] s);
      logic [7:0] r;
      r = s;
      case (op)
         3'h1: begin
            r = {c, s[7:1]};
            c = s[0];
         end
         3'h2: r = {s[3:0], s[7:4]};
         3'h3: if (fa == alu_pkg::DIR_OPERAND) dir = a;
         3'h4: begin
            r = a ^ s;
            z = (r == 8'h00);
         end
         3'h5: begin
            a = a ^ k;
            z = (a == 8'h00);
         end
         default: ;
      endcase
      // destination bit picks acc or file
      if (op inside {3'h1, 3'h2, 3'h4}) begin
         if (d) s = r;
         else a = r;
      end
      return {a, c, z, dir, s};
   endfunction : model_step
   task automatic close_out();
      $display("comparisons %0d mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : close_out
   // ****************************************************************
   // main sequence
   // ****************************************************************
   initial begin
      logic [7:0] a, s, k, m_dir;
      logic c, z, d;
      logic [4:0] fa;
      logic [2:0] op;
      logic [1:0] r;
      logic [31:0] q;
      logic [25:0] m;
      alu_pkg::instr_t iw;
      void'($urandom(42737));
      repeat (3) @(posedge ref_clk_i);
      rst_i <= 1'b0;
      @(posedge ref_clk_i);
      chk("reset state", {24'h0, alu_pkg::DIR_RST}, {14'h0, acc, carry, zero, pin_dir});
      m_dir = alu_pkg::DIR_RST;
      $display("test reset done");
      // all eight codes in turn, no-op and spares too; operands equal every third pass, so xor results are zero
      for (int i = 0; i < 64; i++) begin
         op = 3'(i % 8);
         a = 8'($urandom);
         s = 8'($urandom);
         k = 8'($urandom);
         {c, z, d} = 3'($urandom);
         fa = 5'($urandom);
         if (i % 3 == 0) begin
            k = a;
            s = a;
         end
         if (op == 3'h3) fa = (i % 16 == 3) ? alu_pkg::DIR_OPERAND : 5'h07;
         iw = alu_pkg::INSTR_RST;
         iw.op = op;
         iw.dest = d;
         iw.faddr = fa;
         iw.literal = k;
         wr(32'(alu_pkg::OFS_ACC), {24'h0, a}, r);
         wr(32'(alu_pkg::OFS_STATUS), {30'h0, z, c}, r);
         wr(32'(alu_pkg::OFS_FPTR), {27'h0, fa}, r);
         wr(32'(alu_pkg::OFS_FDATA), {24'h0, s}, r);
         m = model_step(op, d, fa, k, a, c, z, m_dir, s);
         wr(32'(alu_pkg::OFS_INSTR), iw, r);
         chk("core state", {14'h0, m[25:8]}, {14'h0, acc, carry, zero, pin_dir});
         chk("instr resp", {30'h0, alu_pkg::RESP_OKAY}, {30'h0, r});
         rd(32'(alu_pkg::OFS_FDATA), q, r);
         chk("file byte", {24'h0, m[7:0]}, q);
         chk("file resp", {30'h0, alu_pkg::RESP_OKAY}, {30'h0, r});
         rd(32'(alu_pkg::OFS_ACC), q, r);
         chk("acc readback", {24'h0, m[25:18]}, q);
         rd(32'(alu_pkg::OFS_STATUS), q, r);
         chk("status readback", {30'h0, m[16], m[17]}, q);
         rd(32'(alu_pkg::OFS_INSTR), q, r);
         chk("instr readback", iw, q);
         m_dir = m[15:8];
      end
      $display("test operations done");
      // refused and read-only places
      wr(32'h0000_0100, 32'h0, r);
      chk("unmapped write resp", {30'h0, alu_pkg::RESP_SLVERR}, {30'h0, r});
      rd(32'h20, q, r);
      chk("unmapped read", {alu_pkg::RESP_SLVERR, 30'h0}, {r, q[29:0]});
      chk("unmapped read data", 32'h0, q);
      wr(32'(alu_pkg::OFS_DIR), 32'h0, r);
      chk("dir write ignored", {22'h0, alu_pkg::RESP_OKAY, m_dir}, {22'h0, r, pin_dir});
      $display("test errors done");
      close_out();
   end
   // hang guard, well beyond the expected few thousand cycles
   initial begin
      #(20000 * 50);
      err_count++;
      close_out();
   end
endmodule : byte_rotate_swap_xor_alu_tb
